// ===== core/its_cfg.svh
// Constants for the fast-mode I2C target port
`ifndef ITS_CFG_SVH
`define ITS_CFG_SVH

// ========================================
// Clock and timing
`define ITS_CLK_KHZ 10000
`define ITS_STRETCH_MS 20
`define ITS_TSU_NS 100
`define ITS_FM_KBPS 400

// ========================================
// Bus identity and reset values
`define ITS_TARGET_ADDR 7'h42
`define ITS_LINE_IDLE 3'h7
`define ITS_TIMEOUT_BYTE 8'hFF
`define ITS_ADDR_BITS 4'h8

`endif

// ===== core/its_pkg.sv
// Types shared by the fast-mode I2C target port
package its_pkg;

   // ========================================
   // Protocol engine states, one-hot
   typedef enum logic [7:0] {
      ITS_IDLE     = 8'h01,
      ITS_ADDR     = 8'h02,
      ITS_ADDR_ACK = 8'h04,
      ITS_WR_DATA  = 8'h08,
      ITS_WR_ACK   = 8'h10,
      ITS_RD_LOAD  = 8'h20,
      ITS_RD_DATA  = 8'h40,
      ITS_RD_ACK   = 8'h80
   } its_state_type;

endpackage : its_pkg

// ===== core/its_sync.sv
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
module its_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
)(
   input wire logic i_core_clk,     // Core clock
   input wire logic i_reset,        // Asynchronous reset, active high
   input wire logic [W-1:0] i_async, // Asynchronous inputs
   output logic [W-1:0] o_sync      // Synchronised outputs
);

   logic [W-1:0] meta_r;

   // ========================================
   // Two flip-flops; the first is read only by the second
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         meta_r <= RST_VAL;
         o_sync <= RST_VAL;
      end
      else
      begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end

endmodule : its_sync

// ===== core/its_target.sv
// Fast-mode I2C target port with clock stretching
// ========================================
// Overview of operation
// - Port runs in fast-mode only; standard-mode hosts need not be served.
// - Port is a bus target only; host clocks at most 400 kbit/s.
// - Device may hold SCL low to pause; host waits for release.
// - Each SCL stretch lasts at most 20 ms, then SCL is released.
// - SDA data is valid a set-up time before stretched SCL is released.
// - Interface select sampled low disables the port; bus traffic ignored.
// - Interface select open or high enables the I2C port.
`timescale 1ns/1ps
`include "its_cfg.svh"
module its_target #(
   parameter logic [6:0] TARGET_ADDR = `ITS_TARGET_ADDR,
   parameter int unsigned STRETCH_CYCLES = `ITS_STRETCH_MS * `ITS_CLK_KHZ,
   parameter int unsigned CNT_W = $clog2(STRETCH_CYCLES + 1)
)(
   input wire logic i_core_clk,         // Core clock, 10 MHz
   input wire logic i_reset,            // Asynchronous reset, active high
   input wire logic i_if_sel,           // Interface select strap
   input wire logic i_scl,              // SCL line level
   input wire logic i_sda,              // SDA line level
   output logic o_scl_out,              // SCL drive value, always low
   output logic o_scl_oe,               // SCL driven low while high
   output logic o_sda_out,              // SDA drive value, always low
   output logic o_sda_oe,               // SDA driven low while high
   output logic [7:0] o_rx_data,        // Byte written by host
   output logic o_rx_valid,             // Pulse: o_rx_data is new
   input wire logic [7:0] i_tx_data,    // Byte for host read
   input wire logic i_tx_valid,         // i_tx_data offered
   output logic o_tx_ready,             // Port takes read byte now
   output logic o_enabled,              // Port enabled by strap
   output its_pkg::its_state_type o_state // Engine state
);
   import its_pkg::*;

   localparam int unsigned TSU_RAW =
      (`ITS_TSU_NS * `ITS_CLK_KHZ + 999999) / 1000000;
   localparam int unsigned TSU_CYC = (TSU_RAW < 1) ? 1 : TSU_RAW;
   localparam int unsigned TIMEOUT = STRETCH_CYCLES - TSU_CYC - 3;

   // ========================================
   // Elaboration checks
   generate
      if (STRETCH_CYCLES < TSU_CYC + 8 || TSU_CYC > 15
         || CNT_W < $clog2(STRETCH_CYCLES + 1))
      begin : g_bad_timing
         $error("its_target: stretch limit too short for set-up time");
      end
   endgenerate

   // ========================================
   // State and wires
   its_state_type state_r, state_nxt;
   logic [3:0] bitcnt_r, bitcnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [7:0] rx_data_r, rx_data_nxt;
   logic rx_valid_r, rx_valid_nxt;
   logic rw_r, rw_nxt;
   logic ack_r, ack_nxt;
   logic loaded_r, loaded_nxt;
   logic [3:0] setup_r, setup_nxt;
   logic [CNT_W-1:0] stretch_r, stretch_nxt;
   logic sda_oe_r, sda_oe_nxt;
   logic scl_oe_r, scl_oe_nxt;
   logic en_r;
   logic [1:0] samp_r;
   logic scl_d_r, sda_d_r;
   logic scl_s, sda_s, sel_s;
   logic [2:0] sync_out;
   wire logic scl_rise;
   wire logic scl_fall;
   wire logic start_cond;
   wire logic stop_cond;
   wire logic addr_hit;
   wire logic rd_wait;
   wire logic tx_take;
   wire logic timed_out;
   wire logic setup_done;

   // ========================================
   // Pin synchronisers, lines idle high
   its_sync #(
      .W(3),
      .RST_VAL(`ITS_LINE_IDLE)
   ) u_sync (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_async({i_if_sel, i_scl, i_sda}),
      .o_sync(sync_out)
   );
   assign sel_s = sync_out[2];
   assign scl_s = sync_out[1];
   assign sda_s = sync_out[0];

   // Bus condition decode on synchronised lines
   assign scl_rise = scl_s & ~scl_d_r;
   assign scl_fall = ~scl_s & scl_d_r;
   assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_cond = scl_s & scl_d_r & ~sda_d_r & sda_s;
   assign addr_hit = (shift_r[7:1] == TARGET_ADDR);

   // Read byte handshake and stretch limits
   assign rd_wait = en_r & (state_r == ITS_RD_LOAD) & ~loaded_r
      & ~start_cond & ~stop_cond;
   assign tx_take = rd_wait & i_tx_valid;
   assign timed_out = (stretch_r == CNT_W'(TIMEOUT));
   assign setup_done = (setup_r == 4'(TSU_CYC));

   // Outputs
   assign o_scl_out = 1'b0;
   assign o_sda_out = 1'b0;
   assign o_scl_oe = scl_oe_r;
   assign o_sda_oe = sda_oe_r;
   assign o_rx_data = rx_data_r;
   assign o_rx_valid = rx_valid_r;
   assign o_tx_ready = rd_wait;
   assign o_enabled = en_r;
   assign o_state = state_r;

   // ========================================
   // Protocol engine next state
   always_comb
   begin
      state_nxt = state_r;
      bitcnt_nxt = bitcnt_r;
      shift_nxt = shift_r;
      rx_data_nxt = rx_data_r;
      rx_valid_nxt = 1'b0;
      rw_nxt = rw_r;
      ack_nxt = ack_r;
      loaded_nxt = loaded_r;
      setup_nxt = setup_r;
      stretch_nxt = stretch_r;
      sda_oe_nxt = sda_oe_r;
      scl_oe_nxt = scl_oe_r;
      if (!en_r)
      begin
         state_nxt = ITS_IDLE;
         sda_oe_nxt = 1'b0;
         scl_oe_nxt = 1'b0;
      end
      else if (start_cond || stop_cond)
      begin
         state_nxt = start_cond ? ITS_ADDR : ITS_IDLE;
         bitcnt_nxt = 4'h0;
         sda_oe_nxt = 1'b0;
         scl_oe_nxt = 1'b0;
      end
      else
      begin
         case (state_r)
            ITS_IDLE:
            begin
               sda_oe_nxt = 1'b0;
            end
            ITS_ADDR, ITS_WR_DATA:
            begin
               if (scl_rise)
               begin
                  shift_nxt = {shift_r[6:0], sda_s};
                  bitcnt_nxt = bitcnt_r + 4'h1;
               end
               else if (scl_fall && bitcnt_r == `ITS_ADDR_BITS)
               begin
                  bitcnt_nxt = 4'h0;
                  if (state_r == ITS_WR_DATA)
                  begin
                     rx_data_nxt = shift_r;
                     rx_valid_nxt = 1'b1;
                     sda_oe_nxt = 1'b1;
                     state_nxt = ITS_WR_ACK;
                  end
                  else if (addr_hit)
                  begin
                     rw_nxt = shift_r[0];
                     sda_oe_nxt = 1'b1;
                     state_nxt = ITS_ADDR_ACK;
                  end
                  else
                  begin
                     state_nxt = ITS_IDLE;
                  end
               end
            end
            ITS_ADDR_ACK, ITS_WR_ACK:
            begin
               if (scl_fall)
               begin
                  sda_oe_nxt = 1'b0;
                  if (state_r == ITS_ADDR_ACK && rw_r)
                  begin
                     scl_oe_nxt = 1'b1;
                     loaded_nxt = 1'b0;
                     stretch_nxt = '0;
                     state_nxt = ITS_RD_LOAD;
                  end
                  else
                  begin
                     state_nxt = ITS_WR_DATA;
                  end
               end
            end
            ITS_RD_LOAD:
            begin
               stretch_nxt = stretch_r + CNT_W'(1);
               if (!loaded_r)
               begin
                  if (tx_take || timed_out)
                  begin
                     shift_nxt = tx_take ? i_tx_data : `ITS_TIMEOUT_BYTE;
                     sda_oe_nxt = tx_take ? ~i_tx_data[7] : 1'b0;
                     loaded_nxt = 1'b1;
                     setup_nxt = 4'h0;
                  end
               end
               else if (setup_done)
               begin
                  scl_oe_nxt = 1'b0;
                  bitcnt_nxt = 4'h0;
                  state_nxt = ITS_RD_DATA;
               end
               else
               begin
                  setup_nxt = setup_r + 4'h1;
               end
            end
            ITS_RD_DATA:
            begin
               if (scl_fall)
               begin
                  bitcnt_nxt = bitcnt_r + 4'h1;
                  shift_nxt = {shift_r[6:0], 1'b0};
                  sda_oe_nxt = ~shift_r[6];
                  if (bitcnt_r == 4'h7)
                  begin
                     sda_oe_nxt = 1'b0;
                     state_nxt = ITS_RD_ACK;
                  end
               end
            end
            ITS_RD_ACK:
            begin
               if (scl_rise)
               begin
                  ack_nxt = ~sda_s;
               end
               else if (scl_fall)
               begin
                  scl_oe_nxt = ack_r;
                  loaded_nxt = 1'b0;
                  stretch_nxt = '0;
                  state_nxt = ack_r ? ITS_RD_LOAD : ITS_IDLE;
               end
            end
            default:
            begin
               state_nxt = ITS_IDLE;
               sda_oe_nxt = 1'b0;
               scl_oe_nxt = 1'b0;
            end
         endcase
      end
   end

   // ========================================
   // Strap capture after reset release
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         samp_r <= 2'h0;
         en_r <= 1'b0;
      end
      else if (samp_r != 2'h3)
      begin
         samp_r <= samp_r + 2'h1;
         en_r <= (samp_r == 2'h2) ? sel_s : 1'b0;
      end
   end

   // Engine registers
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         state_r <= ITS_IDLE;
         bitcnt_r <= 4'h0;
         shift_r <= 8'h00;
         rx_data_r <= 8'h00;
         rx_valid_r <= 1'b0;
         rw_r <= 1'b0;
         ack_r <= 1'b0;
         loaded_r <= 1'b0;
         setup_r <= 4'h0;
         stretch_r <= '0;
         sda_oe_r <= 1'b0;
         scl_oe_r <= 1'b0;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         state_r <= state_nxt;
         bitcnt_r <= bitcnt_nxt;
         shift_r <= shift_nxt;
         rx_data_r <= rx_data_nxt;
         rx_valid_r <= rx_valid_nxt;
         rw_r <= rw_nxt;
         ack_r <= ack_nxt;
         loaded_r <= loaded_nxt;
         setup_r <= setup_nxt;
         stretch_r <= stretch_nxt;
         sda_oe_r <= sda_oe_nxt;
         scl_oe_r <= scl_oe_nxt;
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // ========================================
   // Assertions
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);

   ack_drive_time_a: assert property (
      (en_r && !start_cond && !stop_cond && state_r == ITS_ADDR
         && scl_fall && bitcnt_r == `ITS_ADDR_BITS && addr_hit)
      |=> (sda_oe_r && state_r == ITS_ADDR_ACK))
      else $error("address acknowledge not driven");
   scl_only_stretch_a: assert property (
      o_scl_oe |-> (state_r == ITS_RD_LOAD && en_r))
      else $error("SCL driven outside a read stretch");
   stretch_holds_a: assert property (
      (state_r == ITS_RD_LOAD && $past(state_r) == ITS_RD_LOAD
         && !loaded_r) |-> o_scl_oe)
      else $error("SCL released before read byte loaded");
   stretch_limit_a: assert property (
      o_scl_oe |-> (stretch_r < CNT_W'(STRETCH_CYCLES)))
      else $error("clock stretch exceeds limit");
   data_setup_a: assert property (
      $fell(scl_oe_r) && $past(state_r) == ITS_RD_LOAD
      |-> ($past(loaded_r, 2) && $stable(sda_oe_r)
         && $past(sda_oe_r, 2) == sda_oe_r))
      else $error("SDA not set up before SCL release");
   disabled_idle_a: assert property (
      (!en_r && samp_r == 2'h3) |=> (!o_scl_oe && !o_sda_oe
         && state_r == ITS_IDLE && !o_tx_ready))
      else $error("disabled port touches the bus");
   start_enters_a: assert property (
      (en_r && start_cond) |=> (state_r == ITS_ADDR && bitcnt_r == 4'h0))
      else $error("start not taken while enabled");

   write_byte_c: cover property (o_rx_valid);
   read_byte_c: cover property (tx_take);
   stretch_timeout_c: cover property (rd_wait && timed_out);
   disabled_c: cover property (samp_r == 2'h3 && !en_r && start_cond);

endmodule : its_target

// ===== tb/its_host_model.sv
// Behavioural fast-mode I2C host controller for the target port
`timescale 1ns/1ps
module its_host_model (
   input wire logic i_scl,  // Resolved SCL level
   input wire logic i_sda,  // Resolved SDA level
   output logic o_scl_oe,   // Pulls SCL low while high
   output logic o_sda_oe    // Pulls SDA low while high
);
   // ========================================
   // Bus timing: 2.5 us period, 400 kHz
   localparam int T_LOW = 1600;
   localparam int T_HIGH = 900;
   localparam int T_HD = 600;

   // Both lines released at start
   initial
   begin
      o_scl_oe = 1'b0;
      o_sda_oe = 1'b0;
   end

   // Release SCL and wait while the target stretches it
   task automatic rise_scl;
      int n;
      o_scl_oe = 1'b0;
      n = 0;
      while (i_scl !== 1'b1 && n < 20000)
      begin
         #100;
         n++;
      end
   endtask : rise_scl

   // One clock pulse: drive b, sample the wire mid-high
   task automatic clock_bit(input logic b, output logic s);
      #100;
      o_sda_oe = ~b;
      #(T_LOW - 100);
      rise_scl();
      #(T_HIGH / 2);
      s = i_sda;
      #(T_HIGH / 2);
      o_scl_oe = 1'b1;
   endtask : clock_bit

   // Start condition from an idle bus
   task automatic i2c_start;
      o_sda_oe = 1'b1;
      #(T_HD);
      o_scl_oe = 1'b1;
   endtask : i2c_start

   // Stop condition, then bus-free time
   task automatic i2c_stop;
      #100;
      o_sda_oe = 1'b1;
      #(T_LOW);
      rise_scl();
      #(T_HD);
      o_sda_oe = 1'b0;
      #(T_LOW);
   endtask : i2c_stop

   // Eight data bits MSB first, then the acknowledge bit
   task automatic xfer(input logic [7:0] d, input logic ack_in,
                       output logic [7:0] q, output logic ack_out);
      for (int i = 7; i >= 0; i--)
         clock_bit(d[i], q[i]);
      clock_bit(ack_in, ack_out);
   endtask : xfer
endmodule : its_host_model

// ===== tb/test_its_target.sv
// Self-checking bench for the fast-mode I2C target port
`timescale 1ns/1ps
`include "its_cfg.svh"
module test_its_target;
   import its_pkg::*;
   localparam int STRETCH = 64;
   localparam logic [6:0] ADDR = `ITS_TARGET_ADDR;
   logic clk, rst, sel, tx_valid, tx_ready, rx_valid, enabled;
   logic scl_oe, sda_oe, h_scl_oe, h_sda_oe, a, scl_out, sda_out;
   logic [7:0] tx_data, rx_data, q;
   its_state_type state;
   wire logic scl;
   wire logic sda;
   logic [7:0] rx_q[$];
   int errors, n_checks, run_str, max_str;

   // ========================================
   // Open-drain wires with pull-ups
   assign scl = (scl_oe ? scl_out : 1'b1) & ~h_scl_oe;
   assign sda = (sda_oe ? sda_out : 1'b1) & ~h_sda_oe;

   its_target #(.STRETCH_CYCLES(STRETCH)) dut (.i_core_clk(clk),
      .i_reset(rst), .i_if_sel(sel), .i_scl(scl), .i_sda(sda),
      .o_scl_out(scl_out), .o_scl_oe(scl_oe), .o_sda_out(sda_out),
      .o_sda_oe(sda_oe),
      .o_rx_data(rx_data), .o_rx_valid(rx_valid), .i_tx_data(tx_data),
      .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_enabled(enabled),
      .o_state(state));

   its_host_model host (.i_scl(scl), .i_sda(sda), .o_scl_oe(h_scl_oe),
      .o_sda_oe(h_sda_oe));

   // Core clock, 100 ns period
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Capture written bytes and the longest stretch, off the edge
   always @(negedge clk)
   begin
      if (rx_valid === 1'b1) rx_q.push_back(rx_data);
      run_str = (scl_oe === 1'b1) ? run_str + 1 : 0;
      if (run_str > max_str) max_str = run_str;
   end

   // ========================================
   // Compare and support tasks
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask : chk1

   task automatic do_reset(input logic s);
      @(posedge clk);
      #1 rst = 1'b1;
      sel = s;
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      repeat (6) @(posedge clk);
      #1;
   endtask : do_reset

   // Offer a read byte after a stall; held until taken
   task automatic give(input logic [7:0] d, input int stall);
      repeat (stall + 1) @(posedge clk);
      #1 tx_data = d;
      tx_valid = 1'b1;
      do @(negedge clk); while (tx_ready !== 1'b1);
      @(posedge clk);
      #1 tx_valid = 1'b0;
   endtask : give

   // ========================================
   // Scenarios
   task automatic test_write;
      rx_q.delete();
      host.i2c_start();
      host.xfer({ADDR, 1'b0}, 1'b1, q, a);
      chk1(a, 1'b0);
      host.xfer(8'h5A, 1'b1, q, a);
      chk1(a, 1'b0);
      host.xfer(8'h81, 1'b1, q, a);
      chk1(a, 1'b0);
      host.i2c_stop();
      chk8(8'(rx_q.size()), 8'h02);
      chk8(rx_q[0], 8'h5A);
      chk8(rx_q[1], 8'h81);
      $display("test write done");
   endtask : test_write

   task automatic test_read;
      host.i2c_start();
      host.xfer({ADDR, 1'b1}, 1'b1, q, a);
      chk1(a, 1'b0);
      fork
         give(8'hA5, 0);
         host.xfer(8'hFF, 1'b0, q, a);
      join
      chk8(q, 8'hA5);
      fork
         give(8'h3C, 20);
         host.xfer(8'hFF, 1'b1, q, a);
      join
      chk8(q, 8'h3C);
      host.i2c_stop();
      $display("test read done");
   endtask : test_read

   task automatic test_timeout;
      host.i2c_start();
      host.xfer({ADDR, 1'b1}, 1'b1, q, a);
      host.xfer(8'hFF, 1'b1, q, a);
      chk8(q, `ITS_TIMEOUT_BYTE);
      host.i2c_stop();
      chk1(max_str <= STRETCH, 1'b1);
      $display("test timeout done");
   endtask : test_timeout

   task automatic test_wrong_addr;
      rx_q.delete();
      host.i2c_start();
      host.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
      chk1(a, 1'b1);
      #1000;
      chk8(state, ITS_IDLE);
      host.xfer(8'h66, 1'b1, q, a);
      chk1(a, 1'b1);
      host.i2c_stop();
      chk8(8'(rx_q.size()), 8'h00);
      chk8(state, ITS_IDLE);
      $display("test wrong address done");
   endtask : test_wrong_addr

   task automatic test_disabled;
      do_reset(1'b0);
      rx_q.delete();
      chk1(enabled, 1'b0);
      host.i2c_start();
      host.xfer({ADDR, 1'b0}, 1'b1, q, a);
      chk1(a, 1'b1);
      host.xfer(8'h77, 1'b1, q, a);
      chk1(a, 1'b1);
      host.i2c_stop();
      chk8(8'(rx_q.size()), 8'h00);
      host.i2c_start();
      host.xfer({ADDR, 1'b1}, 1'b1, q, a);
      chk1(a, 1'b1);
      #1000;
      chk1(tx_ready, 1'b0);
      host.i2c_stop();
      $display("test disabled done");
   endtask : test_disabled

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   // Watchdog, far beyond the expected 0.35 ms run
   initial
   begin
      #3000000;
      errors++;
      $display("watchdog expired");
      end_of_test();
   end

   // Main sequence
   initial
   begin
      errors = 0;
      n_checks = 0;
      run_str = 0;
      max_str = 0;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      rst = 1'b1;
      sel = 1'b1;
      do_reset(1'b1);
      chk1(enabled, 1'b1);
      test_write();
      test_read();
      test_timeout();
      test_wrong_addr();
      test_disabled();
      end_of_test();
   end
endmodule : test_its_target
